// File: rtl/scg_backlight.sv
// Display backlight hold timer, counted in millisecond ticks
`timescale 1ns/1ns
module scg_backlight
	import scg_pkg::*;
#(
	parameter int HOLD_MS = BACKLIGHT_MS
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ms_tick,
	input  wire logic press,
	output logic      light_on
);
	logic [MS_W-1:0] remain;
	logic [MS_W-1:0] next_remain;
	logic            next_light_on;

	// A press restarts the full hold time, even while already lit
	always_comb begin
		next_remain   = remain;
		next_light_on = light_on;
		if (press) begin
			next_remain   = MS_W'(HOLD_MS);
			next_light_on = 1'b1;
		end else if (ms_tick && remain != '0) begin
			next_remain   = remain - MS_W'(1);
			next_light_on = (remain != MS_W'(1));
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			remain   <= '0;
			light_on <= 1'b0;
		end else begin
			remain   <= next_remain;
			light_on <= next_light_on;
		end
	end

	chk_press_lights: assert property (@(posedge clk) disable iff (!rst_n)
		press |=> light_on && remain == MS_W'(HOLD_MS))
		else $error("Backlight not lit for full hold after press");
endmodule : scg_backlight

// File: rtl/scg_lamp.sv
// Two-colour lamp driver: maps a lamp mode and blink phase to colour bits
`timescale 1ns/1ns
module scg_lamp
	import scg_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	scg_lamp_if.lamp  lp
);
	scg_lamp_color_t next_color;
	scg_lamp_color_t color;

	// Exactly one mode at a time, so colours never mix across states
	always_comb begin
		next_color = '0;
		case (lp.mode)
			SCG_LAMP_FLASH_GREEN: next_color.green = lp.blink;
			SCG_LAMP_GREEN:       next_color.green = 1'b1;
			SCG_LAMP_ORANGE: begin
				next_color.green = 1'b1;
				next_color.red   = 1'b1;
			end
			SCG_LAMP_FLASH_RED:   next_color.red = lp.blink;
			SCG_LAMP_RED:         next_color.red = 1'b1;
			default:              next_color = '0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			color <= '0;
		end else begin
			color <= next_color;
		end
	end

	assign lp.color = color;

	chk_steady_red_only: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n) && $past(lp.mode) == SCG_LAMP_RED |-> color.red && !color.green)
		else $error("Red lamp mode did not give pure red");
endmodule : scg_lamp

// File: rtl/scg_lamp_if.sv
// Carrier between the controller and one lamp driver
`timescale 1ns/1ns
interface scg_lamp_if;
	import scg_pkg::*;
	scg_lamp_mode_t  mode;
	logic            blink;
	scg_lamp_color_t color;
	modport ctrl (output mode, output blink, input color);
	modport lamp (input mode, input blink, output color);
endinterface : scg_lamp_if

// File: rtl/scg_pkg.sv
// Shared constants and types for the scanner status and gate control block
package scg_pkg;
	localparam int CLK_HZ          = 20_000_000;
	localparam int MS_PER_S        = 1_000;
	localparam int TICK_MS         = 1;
	localparam int TICK_CYCLES     = CLK_HZ / MS_PER_S * TICK_MS;
	localparam int BLINK_HALF_MS   = 250;
	localparam int BACKLIGHT_MIN   = 10;
	localparam int MS_PER_MIN      = 60_000;
	localparam int BACKLIGHT_MS    = BACKLIGHT_MIN * MS_PER_MIN;
	localparam int QUALITY_FULL    = 100;
	localparam int NUM_LINES       = 4;
	localparam int NUM_BUTTONS     = 4;
	localparam int LINE_GATE_A     = 0;
	localparam int LINE_LEARN      = 1;
	localparam int LINE_GATE_B     = 2;
	localparam int BTN_UP          = 0;
	localparam int BTN_DOWN        = 1;
	localparam int BTN_CONFIRM     = 2;
	localparam int BTN_CANCEL      = 3;
	localparam int TICK_W          = 15;
	localparam int MS_W            = 20;
	localparam logic [7:0] ZERO8   = 8'h00;

	typedef enum logic [2:0] {
		SCG_LAMP_OFF,
		SCG_LAMP_FLASH_GREEN,
		SCG_LAMP_GREEN,
		SCG_LAMP_ORANGE,
		SCG_LAMP_FLASH_RED,
		SCG_LAMP_RED
	} scg_lamp_mode_t;

	typedef struct packed {
		logic green;
		logic red;
	} scg_lamp_color_t;
endpackage : scg_pkg

// File: rtl/scg_status_gate.sv
// Status lamps, display flags, buttons and reading-gate control of the scanner
`timescale 1ns/1ns
// Overview of operation
// - During self-test and init, power lamp flashes green and reading is blocked.
// - After successful self-test, power lamp steady green and reading allowed.
// - Service mode: power lamp orange, reading allowed, host output muted.
// - Warning: power lamp flashes red, reading still allowed.
// - Device error or parameter enable: power lamp steady red, reading blocked.
// - While network is being established, network lamp flashes green.
// - Healthy cyclic data exchange: network lamp steady green.
// - Parameter, configuration or IO failure: network lamp flashes red.
// - No protocol connection to host: network lamp steady red.
// - Each active switching line shows its display indicator.
// - After reset lines one and three trigger the gate, line two starts learn.
// - After reset line four signals a failed read.
// - Internal error flag for factory faults, separate from warning flag.
// - Read quality shown as zero to hundred percent from equal scans.
// - Flag for attached parameter store; PC flag for connected PC only while no store is attached.
// - Any button press lights the backlight for ten minutes.
// - Up/down move selection, confirm activates, cancel goes one level up.
// - Line, fieldbus or reflector trigger opens a reading window.
// - Reflector mode keeps gate closed while reflector is seen.
// - Reflector blocked opens gate; cleared path closes gate, reduces beam.
// - Learn captures type and digits of next code, then only matches decode.
// - After accepted export, each later config change is written to the store while it stays attached.
module scg_status_gate
	import scg_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYCLES,
	parameter int BLINK_MS = BLINK_HALF_MS,
	parameter int HOLD_MS  = BACKLIGHT_MS
) (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 init_done,
	input  wire logic                 service_mode,
	input  wire logic                 warning_in,
	input  wire logic                 device_error,
	input  wire logic                 param_enable,
	input  wire logic                 factory_fault,
	input  wire logic                 net_connecting,
	input  wire logic                 net_exchange,
	input  wire logic                 net_param_fail,
	input  wire logic                 net_io_error,
	input  wire logic                 net_no_protocol,
	input  wire logic [NUM_LINES-2:0] switching_lines,
	input  wire logic                 host_trigger,
	input  wire logic                 refl_mode,
	input  wire logic                 reflector_seen,
	input  wire logic                 learn_display,
	input  wire logic                 learn_host,
	input  wire logic                 decode_valid,
	input  wire logic [7:0]           decode_type,
	input  wire logic [7:0]           decode_digits,
	input  wire logic [7:0]           equal_scans_cfg,
	input  wire logic [7:0]           equal_scans_seen,
	input  wire logic [NUM_BUTTONS-1:0] buttons,
	input  wire logic                 pc_connected,
	input  wire logic                 store_attached,
	input  wire logic                 export_accept,
	input  wire logic                 config_change,
	output logic                      power_state_lamp_green,
	output logic                      power_state_lamp_red,
	output logic                      network_state_lamp_green,
	output logic                      network_state_lamp_red,
	output logic                      switching_line_four,
	output logic [NUM_LINES-1:0]      line_indicator,
	output logic                      warning_flag,
	output logic                      internal_error_flag,
	output logic                      param_store_present_flag,
	output logic                      pc_flag,
	output logic [6:0]                quality_pct,
	output logic                      backlight,
	output logic                      menu_up,
	output logic                      menu_down,
	output logic                      menu_confirm,
	output logic                      menu_back,
	output logic                      reading_enable,
	output logic                      host_tx_enable,
	output logic                      gate_open,
	output logic                      beam_reduced,
	output logic                      learn_active,
	output logic                      code_locked,
	output logic [7:0]                locked_type,
	output logic [7:0]                locked_digits,
	output logic                      decode_accept,
	output logic                      store_write
);
	scg_lamp_if pwr_if ();
	scg_lamp_if net_if ();

	// Millisecond tick and blink phase dividers
	logic [TICK_W-1:0] tick_cnt, next_tick_cnt;
	logic [9:0]        blink_cnt, next_blink_cnt;
	logic              ms_tick, next_ms_tick, blink, next_blink;

	always_comb begin
		next_tick_cnt  = tick_cnt + TICK_W'(1);
		next_ms_tick   = 1'b0;
		next_blink_cnt = blink_cnt;
		next_blink     = blink;
		if (tick_cnt == TICK_W'(TICK_CYC - 1)) begin
			next_tick_cnt = '0;
			next_ms_tick  = 1'b1;
		end
		if (ms_tick) begin
			next_blink_cnt = blink_cnt + 10'(1);
			if (blink_cnt == 10'(BLINK_MS - 1)) begin
				next_blink_cnt = '0;
				next_blink     = !blink;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tick_cnt  <= '0;
			ms_tick   <= 1'b0;
			blink_cnt <= '0;
			blink     <= 1'b0;
		end else begin
			tick_cnt  <= next_tick_cnt;
			ms_tick   <= next_ms_tick;
			blink_cnt <= next_blink_cnt;
			blink     <= next_blink;
		end
	end

	// Lamp mode selection; error is checked first so it wins
	logic dev_fault;
	assign dev_fault = device_error || param_enable;

	always_comb begin
		pwr_if.blink = blink;
		net_if.blink = blink;
		if (dev_fault)
			pwr_if.mode = SCG_LAMP_RED;
		else if (!init_done)
			pwr_if.mode = SCG_LAMP_FLASH_GREEN;
		else if (warning_in)
			pwr_if.mode = SCG_LAMP_FLASH_RED;
		else if (service_mode)
			pwr_if.mode = SCG_LAMP_ORANGE;
		else
			pwr_if.mode = SCG_LAMP_GREEN;
		if (net_no_protocol)
			net_if.mode = SCG_LAMP_RED;
		else if (net_param_fail || net_io_error)
			net_if.mode = SCG_LAMP_FLASH_RED;
		else if (net_exchange)
			net_if.mode = SCG_LAMP_GREEN;
		else if (net_connecting)
			net_if.mode = SCG_LAMP_FLASH_GREEN;
		else
			net_if.mode = SCG_LAMP_OFF;
	end

	scg_lamp u_pwr (.clk(clk), .rst_n(rst_n), .lp(pwr_if.lamp));
	scg_lamp u_net (.clk(clk), .rst_n(rst_n), .lp(net_if.lamp));

	assign power_state_lamp_green   = pwr_if.color.green;
	assign power_state_lamp_red     = pwr_if.color.red;
	assign network_state_lamp_green = net_if.color.green;
	assign network_state_lamp_red   = net_if.color.red;

	// Buttons: one edge detector per button
	logic [NUM_BUTTONS-1:0] btn_q, btn_edge, next_btn_edge;
	genvar gi;
	generate
		for (gi = 0; gi < NUM_BUTTONS; gi++) begin : g_btn
			always_comb next_btn_edge[gi] = buttons[gi] && !btn_q[gi];
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					btn_q[gi]    <= 1'b0;
					btn_edge[gi] <= 1'b0;
				end else begin
					btn_q[gi]    <= buttons[gi];
					btn_edge[gi] <= next_btn_edge[gi];
				end
			end
		end
	endgenerate

	assign menu_up      = btn_edge[BTN_UP];
	assign menu_down    = btn_edge[BTN_DOWN];
	assign menu_confirm = btn_edge[BTN_CONFIRM];
	assign menu_back    = btn_edge[BTN_CANCEL];

	scg_backlight #(.HOLD_MS(HOLD_MS)) u_bl (
		.clk      (clk),
		.rst_n    (rst_n),
		.ms_tick  (ms_tick),
		.press    (|next_btn_edge),
		.light_on (backlight)
	);

	// Reading gate, learn lock, flags and store mirroring
	logic       next_reading_enable, next_host_tx, next_gate, next_beam, next_line4;
	logic       next_learn, next_locked, next_accept, next_store_write;
	logic       learn_q, next_learn_q, read_seen, next_read_seen;
	logic       exported, next_exported;
	logic [7:0] next_type, next_digits;
	logic [6:0] next_quality;
	logic [3:0] next_ind;
	logic [15:0] q_scaled;
	logic       trigger, code_match;

	assign trigger    = refl_mode ? !reflector_seen
	                  : (switching_lines[LINE_GATE_A] || switching_lines[LINE_GATE_B]
	                     || host_trigger);
	assign code_match = !code_locked
	                  || (decode_type == locked_type && decode_digits == locked_digits);
	assign q_scaled   = (equal_scans_cfg == ZERO8) ? 16'h0000
	                  : 16'(equal_scans_seen) * 16'(QUALITY_FULL) / 16'(equal_scans_cfg);

	always_comb begin
		next_reading_enable = init_done && !dev_fault;
		next_host_tx        = !service_mode;
		next_gate           = next_reading_enable && trigger;
		next_beam           = refl_mode && !next_gate;
		next_learn_q        = switching_lines[LINE_LEARN];
		next_learn          = learn_active;
		next_locked         = code_locked;
		next_type           = locked_type;
		next_digits         = locked_digits;
		next_accept         = 1'b0;
		next_read_seen      = read_seen;
		next_line4          = switching_line_four;
		// Learn start from line two edge, display or host
		if (learn_display || learn_host || (next_learn_q && !learn_q))
			next_learn = 1'b1;
		if (gate_open && decode_valid) begin
			if (learn_active) begin
				next_learn  = 1'b0;
				next_locked = 1'b1;
				next_type   = decode_type;
				next_digits = decode_digits;
				next_accept = 1'b1;
				next_read_seen = 1'b1;
			end else if (code_match) begin
				next_accept    = 1'b1;
				next_read_seen = 1'b1;
			end
		end
		// No-read output holds until the next gate opens
		if (next_gate && !gate_open) begin
			next_read_seen = 1'b0;
			next_line4     = 1'b0;
		end else if (gate_open && !next_gate) begin
			next_line4 = !next_read_seen;
		end
		next_ind = {next_line4, switching_lines};
		next_quality = (q_scaled > 16'(QUALITY_FULL)) ? 7'(QUALITY_FULL)
		             : q_scaled[6:0];
		// Store mirroring lasts while the stick stays attached
		next_exported = store_attached && (exported || export_accept);
		next_store_write = exported && store_attached && config_change;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reading_enable           <= 1'b0;
			host_tx_enable           <= 1'b0;
			gate_open                <= 1'b0;
			beam_reduced             <= 1'b0;
			learn_q                  <= 1'b0;
			learn_active             <= 1'b0;
			code_locked              <= 1'b0;
			locked_type              <= ZERO8;
			locked_digits            <= ZERO8;
			decode_accept            <= 1'b0;
			read_seen                <= 1'b0;
			switching_line_four      <= 1'b0;
			line_indicator           <= '0;
			quality_pct              <= '0;
			exported                 <= 1'b0;
			store_write              <= 1'b0;
			warning_flag             <= 1'b0;
			internal_error_flag      <= 1'b0;
			param_store_present_flag <= 1'b0;
			pc_flag                  <= 1'b0;
		end else begin
			reading_enable           <= next_reading_enable;
			host_tx_enable           <= next_host_tx;
			gate_open                <= next_gate;
			beam_reduced             <= next_beam;
			learn_q                  <= next_learn_q;
			learn_active             <= next_learn;
			code_locked              <= next_locked;
			locked_type              <= next_type;
			locked_digits            <= next_digits;
			decode_accept            <= next_accept;
			read_seen                <= next_read_seen;
			switching_line_four      <= next_line4;
			line_indicator           <= next_ind;
			quality_pct              <= next_quality;
			exported                 <= next_exported;
			store_write              <= next_store_write;
			warning_flag             <= warning_in;
			internal_error_flag      <= factory_fault;
			param_store_present_flag <= store_attached;
			pc_flag                  <= pc_connected && !store_attached;
		end
	end

	sequence s_refl_blocked;
		refl_mode && !reflector_seen && init_done && !dev_fault;
	endsequence

	sequence s_refl_cleared;
		refl_mode && reflector_seen;
	endsequence

	chk_init_blocks_read: assert property (@(posedge clk) disable iff (!rst_n)
		!init_done |=> !reading_enable && !gate_open)
		else $error("Reading allowed before init done");
	chk_error_blocks_read: assert property (@(posedge clk) disable iff (!rst_n)
		dev_fault |=> !reading_enable && !gate_open)
		else $error("Reading allowed during device error");
	chk_healthy_read: assert property (@(posedge clk) disable iff (!rst_n)
		init_done && !dev_fault |=> reading_enable)
		else $error("Reading not enabled when healthy");
	chk_service_mute: assert property (@(posedge clk) disable iff (!rst_n)
		service_mode |=> !host_tx_enable)
		else $error("Host output active in service mode");
	chk_error_over_warn: assert property (@(posedge clk) disable iff (!rst_n)
		dev_fault && warning_in |=> power_state_lamp_red && !power_state_lamp_green)
		else $error("Warning not overridden by error");
	chk_net_no_proto: assert property (@(posedge clk) disable iff (!rst_n)
		net_no_protocol [*2] |=> network_state_lamp_red && !network_state_lamp_green)
		else $error("Network lamp not steady red");
	chk_refl_gate_open: assert property (@(posedge clk) disable iff (!rst_n)
		s_refl_blocked |=> gate_open && !beam_reduced)
		else $error("Gate not opened on blocked reflector");
	chk_refl_gate_shut: assert property (@(posedge clk) disable iff (!rst_n)
		s_refl_cleared |=> !gate_open && beam_reduced)
		else $error("Gate open while reflector seen");
	chk_lock_filters: assert property (@(posedge clk) disable iff (!rst_n)
		code_locked && !learn_active && decode_valid && decode_type != locked_type
		|=> !decode_accept)
		else $error("Mismatched code accepted after learn");
	chk_noread_out: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(gate_open) |-> switching_line_four == !read_seen)
		else $error("No-read output not raised");
	chk_store_mirror: assert property (@(posedge clk) disable iff (!rst_n)
		exported && store_attached && config_change |=> store_write)
		else $error("Config change not written to store");
	chk_indicator: assert property (@(posedge clk) disable iff (!rst_n)
		switching_lines[LINE_GATE_A] |=> line_indicator[LINE_GATE_A])
		else $error("Line indicator missing");
endmodule : scg_status_gate

// File: testbench/scg_field_model.sv
// Stand-in for the code decoder that reports reads while the gate is open
`timescale 1ns/1ns
module scg_field_model (
	input  wire logic clk,
	output logic      decode_valid,
	output logic [7:0] decode_type,
	output logic [7:0] decode_digits
);
	logic [7:0] t_q;
	logic [7:0] d_q;
	logic [7:0] noise;
	logic       req;
	initial begin
		{decode_valid, decode_type, decode_digits} = '0;
		{t_q, d_q, req} = '0;
		noise = 8'h5a;
	end
	// Idle data keeps moving so a stale code never looks valid
	always @(negedge clk) begin
		noise         <= noise + 8'h3b;
		decode_valid  <= req;
		decode_type   <= req ? t_q : noise;
		decode_digits <= req ? d_q : ~noise;
		req           <= 1'b0;
	end
	// One decoder result pulse per call
	task automatic present(input logic [7:0] t, input logic [7:0] d);
		@(posedge clk);
		t_q = t;
		d_q = d;
		req = 1'b1;
		repeat (3) @(posedge clk);
	endtask : present
endmodule : scg_field_model

// File: testbench/scg_status_gate_tb.sv
// Self-checking bench for the status, button and reading-gate block
`timescale 1ns/1ns
module scg_status_gate_tb;
	import scg_pkg::*;
	logic clk, rst_n, init_done, service_mode, warning_in, device_error, param_enable;
	logic factory_fault, net_connecting, net_exchange, net_param_fail, net_io_error;
	logic net_no_protocol, host_trigger, refl_mode, reflector_seen, learn_display;
	logic learn_host, decode_valid, pc_connected, store_attached, export_accept;
	logic config_change, power_state_lamp_green, power_state_lamp_red;
	logic network_state_lamp_green, network_state_lamp_red, switching_line_four;
	logic warning_flag, internal_error_flag, param_store_present_flag, pc_flag;
	logic backlight, menu_up, menu_down, menu_confirm, menu_back, reading_enable;
	logic host_tx_enable, gate_open, beam_reduced, learn_active, code_locked;
	logic decode_accept, store_write;
	logic [2:0] switching_lines;
	logic [3:0] buttons, line_indicator;
	logic [6:0] quality_pct;
	logic [7:0] decode_type, decode_digits, equal_scans_cfg, equal_scans_seen;
	logic [7:0] locked_type, locked_digits;
	logic [7:0] n_acc = 8'h00;
	logic [7:0] n_wr = 8'h00;
	logic [7:0] n_menu [4] = '{default: 8'h00};
	int n_mismatch = 0;
	int compares = 0;
	int cyc = 0;
	logic [4:0] pw_in [6] = '{5'h00, 5'h01, 5'h03, 5'h05, 5'h17, 5'h09};
	logic [3:0] pw_exp [6] = '{4'hd, 4'h9, 4'ha, 4'h7, 4'h6, 4'h6};
	logic [5:0] pw_re = 6'b001110;
	logic [4:0] nt_in [6] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h1f};
	logic [3:0] nt_exp [6] = '{4'hd, 4'h9, 4'h7, 4'h7, 4'h6, 4'h6};

	// Short counts keep blink at 8 cycles and backlight hold near 20
	scg_status_gate #(.TICK_CYC(4), .BLINK_MS(2), .HOLD_MS(5)) scg_status_gate_i (.*);
	scg_field_model scg_field_model_i (.clk, .decode_valid, .decode_type, .decode_digits);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Pulse outputs are counted so a late or doubled pulse still shows
	always @(posedge clk) begin
		n_acc     <= n_acc + decode_accept;
		n_wr      <= n_wr + store_write;
		n_menu[0] <= n_menu[0] + menu_up;
		n_menu[1] <= n_menu[1] + menu_down;
		n_menu[2] <= n_menu[2] + menu_confirm;
		n_menu[3] <= n_menu[3] + menu_back;
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask : wt
	// Seen mask {green high, green low, red high, red low} over several blinks
	task automatic lamp(input string nm, input bit net, input logic [3:0] exp);
		logic [3:0] seen;
		seen = 4'h0;
		wt(43);
		for (int k = 0; k < 40; k++) begin
			@(negedge clk);
			if (net)
				seen |= {network_state_lamp_green, !network_state_lamp_green,
					network_state_lamp_red, !network_state_lamp_red};
			else
				seen |= {power_state_lamp_green, !power_state_lamp_green,
					power_state_lamp_red, !power_state_lamp_red};
		end
		chk(nm, {4'h0, exp}, {4'h0, seen});
	endtask : lamp
	task automatic cfg_pulse;
		config_change = 1'b1;
		wt(1);
		config_change = 1'b0;
		wt(3);
	endtask : cfg_pulse
	task automatic tally_and_finish;
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	initial begin
		{rst_n, init_done, service_mode, warning_in, device_error, param_enable} = '0;
		{factory_fault, net_connecting, net_exchange, net_param_fail, net_io_error} = '0;
		{net_no_protocol, switching_lines, host_trigger, refl_mode, reflector_seen} = '0;
		{learn_display, learn_host, equal_scans_cfg, equal_scans_seen, buttons} = '0;
		{pc_connected, store_attached, export_accept, config_change} = '0;
		wt(6);
		chk("reset_lamp", 1'b0, power_state_lamp_green);
		rst_n = 1'b1;
		for (int i = 0; i < 6; i++) begin
			{device_error, param_enable, warning_in, service_mode, init_done} = pw_in[i];
			lamp("power_lamp", 1'b0, pw_exp[i]);
			chk("reading_enable", pw_re[i], reading_enable);
			if (i == 0) chk("net_off", 8'h00, {network_state_lamp_green, network_state_lamp_red});
			if (i == 1 || i == 2) chk("host_tx", i == 1, host_tx_enable);
			if (i == 3) chk("warning_flag", 1'b1, warning_flag);
		end
		{device_error, param_enable, warning_in, service_mode, init_done} = 5'h01;
		for (int i = 0; i < 6; i++) begin
			{net_no_protocol, net_io_error, net_param_fail, net_exchange, net_connecting} = nt_in[i];
			lamp("net_lamp", 1'b1, nt_exp[i]);
		end
		switching_lines = 3'h1;
		wt(2);
		chk("gate_line1", 1'b1, gate_open);
		chk("indicator", 8'h01, line_indicator);
		scg_field_model_i.present(8'h41, 8'h0c);
		wt(2);
		chk("accept", 8'h01, n_acc);
		switching_lines = 3'h0;
		wt(2);
		chk("gate_closed", 1'b0, gate_open);
		chk("no_read", 1'b0, switching_line_four);
		switching_lines = 3'h4;
		wt(2);
		chk("gate_line3", 1'b1, gate_open);
		chk("indicator", 8'h04, line_indicator);
		switching_lines = 3'h0;
		wt(2);
		chk("no_read", 1'b1, switching_line_four);
		chk("indicator", 8'h08, line_indicator);
		host_trigger = 1'b1;
		learn_host = 1'b1;
		wt(1);
		learn_host = 1'b0;
		wt(2);
		chk("gate_host", 1'b1, gate_open);
		chk("learn", 1'b1, learn_active);
		scg_field_model_i.present(8'h41, 8'h0c);
		scg_field_model_i.present(8'h41, 8'h0d);
		scg_field_model_i.present(8'h42, 8'h0c);
		wt(2);
		chk("learn_accept", 8'h02, n_acc);
		chk("locked", 1'b1, code_locked);
		chk("locked_type", 8'h41, locked_type);
		chk("locked_digits", 8'h0c, locked_digits);
		scg_field_model_i.present(8'h41, 8'h0c);
		wt(2);
		chk("match_accept", 8'h03, n_acc);
		learn_display = 1'b1;
		wt(1);
		learn_display = 1'b0;
		wt(1);
		chk("learn_disp", 1'b1, learn_active);
		scg_field_model_i.present(8'h43, 8'h0a);
		wt(2);
		chk("relearn_type", 8'h43, locked_type);
		chk("relearn_accept", 8'h04, n_acc);
		host_trigger = 1'b0;
		switching_lines = 3'h2;
		wt(2);
		chk("learn_line2", 1'b1, learn_active);
		{refl_mode, reflector_seen, switching_lines} = 5'h19;
		for (int i = 0; i < 3; i++) begin
			reflector_seen = i != 1;
			wt(2);
			chk("refl_gate", i == 1, gate_open);
			chk("beam_reduced", i != 1, beam_reduced);
		end
		{refl_mode, switching_lines} = 4'h0;
		for (int i = 0; i < 4; i++) begin
			buttons = 4'h1 << i;
			wt(2);
			buttons = 4'h0;
			wt(2);
			chk("menu", 8'h01, n_menu[i]);
		end
		wt(10);
		chk("backlight_on", 1'b1, backlight);
		wt(20);
		chk("backlight_off", 1'b0, backlight);
		factory_fault = 1'b1;
		wt(2);
		chk("internal_error", 1'b1, internal_error_flag);
		chk("warning_apart", 1'b0, warning_flag);
		{equal_scans_cfg, equal_scans_seen} = 16'h0402;
		wt(2);
		chk("quality", 8'h32, {1'b0, quality_pct});
		equal_scans_seen = 8'h08;
		wt(2);
		chk("quality", 8'h64, {1'b0, quality_pct});
		pc_connected = 1'b1;
		wt(2);
		chk("pc_flag", 1'b1, pc_flag);
		store_attached = 1'b1;
		wt(2);
		chk("store_flag", 1'b1, param_store_present_flag);
		chk("pc_hidden", 8'h00, pc_flag);
		cfg_pulse();
		chk("store_idle", 8'h00, n_wr);
		export_accept = 1'b1;
		wt(1);
		export_accept = 1'b0;
		wt(1);
		cfg_pulse();
		cfg_pulse();
		chk("store_write", 8'h02, n_wr);
		store_attached = 1'b0;
		wt(2);
		cfg_pulse();
		chk("store_gone", 8'h02, n_wr);
		tally_and_finish();
	end
endmodule : scg_status_gate_tb
